/* File: lbl_pkg.sv */
package lbl_pkg;

   // ----------------------------------------------------------------------
   // Lane geometry and encodings
   // ----------------------------------------------------------------------
   localparam int          LANES          = 4;
   localparam logic [3:0]  LANES_NONE_N   = 4'hF;   // Active-low: no lane asserted.
   localparam logic [3:0]  LANES_ALL_N    = 4'h0;   // Active-low: all four lanes asserted.
   localparam logic [1:0]  WORDS_ONE      = 2'h0;   // Word count field holds words minus one.
   localparam logic [1:0]  OFFSET_ZERO    = 2'h0;

   // Access size of the first word of a transaction.
   typedef enum logic [1:0] {
      LBL_SIZE_BYTE = 2'h0,
      LBL_SIZE_HALF = 2'h1,
      LBL_SIZE_WORD = 2'h2
   } lbl_size_t;

   // Bus unit states, one-hot.
   typedef enum logic [4:0] {
      LBL_IDLE    = 5'h01,   // idle_state
      LBL_ADDRESS = 5'h02,   // address_state
      LBL_DATA    = 5'h04,   // data_state
      LBL_WAIT    = 5'h08,   // wait_state
      LBL_HOLD    = 5'h10    // bus_released_state
   } lbl_state_t;

   // Transaction request from the processor core.
   typedef struct packed {
      logic [29:0] word_addr;    // Word address, byte address bits dropped.
      logic [1:0]  byte_off;     // Byte offset of the first access.
      lbl_size_t   size;         // Size of the first access.
      logic [1:0]  word_count;   // Number of words minus one.
      logic        cacheable;
      logic        write;
   } lbl_req_t;

endpackage : lbl_pkg

/* File: lbl_lane_mask.sv */
`timescale 1ns/1ps

module lbl_lane_mask
   import lbl_pkg::*;
(
   input  wire lbl_pkg::lbl_size_t size,
   input  wire logic [1:0]         byte_off,
   output logic [3:0]              mask_n
);

   // ----------------------------------------------------------------------
   // Alignment
   // ----------------------------------------------------------------------

   // Low offset bits below the access size are dropped so every access is aligned.
   wire logic [1:0] base_off = (size == LBL_SIZE_WORD) ? OFFSET_ZERO :
                               (size == LBL_SIZE_HALF) ? {byte_off[1], 1'b0} : byte_off;
   wire logic [2:0] last_off = (size == LBL_SIZE_WORD) ? 3'h3 :
                               (size == LBL_SIZE_HALF) ? {1'b0, base_off} + 3'h1 :
                               {1'b0, base_off};

   // ----------------------------------------------------------------------
   // Lane decode
   // ----------------------------------------------------------------------

   // Each lane is asserted when it lies inside the aligned byte span.
   genvar lane;
   generate
      for (lane = 0; lane < LANES; lane++) begin : g_lane
         assign mask_n[lane] = !((3'(lane) >= {1'b0, base_off}) && (3'(lane) <= last_off));
      end
   endgenerate

endmodule : lbl_lane_mask

/* File: lbl_bus_lanes.sv */
`timescale 1ns/1ps

module lbl_bus_lanes (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               interrupt_zero_pin,
   input  wire logic               core_req_valid,
   input  wire lbl_pkg::lbl_req_t  core_req,
   output logic                    core_req_ready,
   output logic                    core_done,
   input  wire logic               ready_n,
   input  wire logic               grant_req_in,
   output logic                    grant_req_out,
   output logic                    bus_outputs_oe,
   output logic [3:0]              byte_lane_strobes_n,
   output logic                    strobes_oe,
   output logic                    cache_out,
   output logic                    cache_oe,
   output lbl_pkg::lbl_state_t     bus_phase,
   output logic                    role_primary
);
   import lbl_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   lbl_state_t  state;
   lbl_state_t  next_state;
   logic        pend_valid;
   lbl_req_t    pend_req;
   logic [1:0]  words_left;
   logic [1:0]  next_words_left;
   logic [3:0]  strobes_n;
   logic [3:0]  next_strobes_n;
   logic        cacheable;
   logic [3:0]  first_mask_n;
   logic        next_pend_valid;

   // ----------------------------------------------------------------------
   // Role and dual-purpose pin meaning
   // ----------------------------------------------------------------------

   // The same input pin is a bus request when primary and a grant when secondary.
   wire logic bus_request_in     = role_primary && grant_req_in;
   wire logic grant_received_in  = !role_primary && grant_req_in;

   // ----------------------------------------------------------------------
   // Request capture
   // ----------------------------------------------------------------------

   // One request is parked until its address state begins.
   wire logic accept     = core_req_valid && core_req_ready;
   wire logic in_xfer    = (state == LBL_ADDRESS) || (state == LBL_DATA) || (state == LBL_WAIT);
   wire logic data_phase = (state == LBL_DATA) || (state == LBL_WAIT);
   wire logic ready      = !ready_n;
   wire logic last_ready = data_phase && ready && (words_left == WORDS_ONE);
   wire logic boundary   = (state == LBL_IDLE) || last_ready;

   // ----------------------------------------------------------------------
   // First word lanes
   // ----------------------------------------------------------------------

   // Bursts always move whole words, so only single transfers use the narrow size.
   wire lbl_size_t first_size = (pend_req.word_count != WORDS_ONE) ? LBL_SIZE_WORD : pend_req.size;

   lbl_lane_mask u_first_mask (
      .size     (first_size),
      .byte_off (pend_req.byte_off),
      .mask_n   (first_mask_n)
   );

   // ----------------------------------------------------------------------
   // Ownership decisions
   // ----------------------------------------------------------------------

   // A start needs a parked request and, as secondary, the grant from outside.
   wire logic may_start  = pend_valid && (role_primary ? !bus_request_in : grant_received_in);
   // The primary hands the bus over only between transactions.
   wire logic give_bus   = role_primary && bus_request_in && boundary;
   // Secondary keeps its request up while it has work parked or in flight.
   wire logic need_bus   = next_pend_valid || (next_state == LBL_ADDRESS) ||
                           (next_state == LBL_DATA) || (next_state == LBL_WAIT);

   // ----------------------------------------------------------------------
   // State sequencing
   // ----------------------------------------------------------------------

   // Next state, remaining words and strobe value for the coming cycle.
   always_comb begin
      next_state      = state;
      next_words_left = words_left;
      next_strobes_n  = strobes_n;
      case (state)
         LBL_IDLE: begin
            if (give_bus) begin
               next_state = LBL_HOLD;
            end else if (may_start) begin
               next_state      = LBL_ADDRESS;
               next_words_left = pend_req.word_count;
               next_strobes_n  = first_mask_n;
            end
         end
         LBL_ADDRESS: begin
            next_state = LBL_DATA;
            if (words_left != WORDS_ONE) begin
               next_strobes_n = LANES_ALL_N;
            end
         end
         LBL_DATA, LBL_WAIT: begin
            if (!ready) begin
               next_state = LBL_WAIT;
            end else if (words_left != WORDS_ONE) begin
               next_state      = LBL_DATA;
               next_words_left = words_left - 2'h1;
               if (words_left != 2'h1) begin
                  next_strobes_n = LANES_ALL_N;
               end
            end else if (give_bus) begin
               next_state = LBL_HOLD;
            end else if (may_start) begin
               next_state      = LBL_ADDRESS;
               next_words_left = pend_req.word_count;
               next_strobes_n  = first_mask_n;
            end else begin
               next_state = LBL_IDLE;
            end
         end
         LBL_HOLD: begin
            if (!bus_request_in) begin
               if (may_start) begin
                  next_state      = LBL_ADDRESS;
                  next_words_left = pend_req.word_count;
                  next_strobes_n  = first_mask_n;
               end else begin
                  next_state = LBL_IDLE;
               end
            end
         end
         default: begin
            next_state = LBL_IDLE;
         end
      endcase
   end

   // Parked request is consumed on entry to the address state.
   wire logic start_now = (next_state == LBL_ADDRESS) && (state != LBL_ADDRESS);
   always_comb begin
      next_pend_valid = pend_valid;
      if (start_now) begin
         next_pend_valid = 1'b0;
      end else if (accept) begin
         next_pend_valid = 1'b1;
      end
   end

   // Outputs are driven only while this device owns the bus for a transfer.
   wire logic next_drive = (next_state == LBL_ADDRESS) || (next_state == LBL_DATA) ||
                           (next_state == LBL_WAIT);

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------

   // Role is taken from the interrupt-zero pin while reset is held.
   always_ff @(posedge clk) begin
      if (srst) begin
         role_primary <= interrupt_zero_pin;
      end
   end

   // Bus state and transfer bookkeeping.
   always_ff @(posedge clk) begin
      if (srst) begin
         state      <= LBL_IDLE;
         words_left <= WORDS_ONE;
         strobes_n  <= LANES_NONE_N;
      end else begin
         state      <= next_state;
         words_left <= next_words_left;
         strobes_n  <= next_strobes_n;
      end
   end

   // Parked request from the core.
   always_ff @(posedge clk) begin
      if (srst) begin
         pend_valid     <= 1'b0;
         core_req_ready <= 1'b0;
      end else begin
         pend_valid     <= next_pend_valid;
         core_req_ready <= !next_pend_valid;
      end
   end

   // Request contents are stored on acceptance.
   always_ff @(posedge clk) begin
      if (srst) begin
         pend_req <= '0;
      end else if (accept) begin
         pend_req <= core_req;
      end
   end

   // Cacheable attribute follows the transaction that is starting.
   always_ff @(posedge clk) begin
      if (srst) begin
         cacheable <= 1'b0;
      end else if (start_now) begin
         cacheable <= pend_req.cacheable;
      end
   end

   // Pin outputs, all taken from flip-flops.
   always_ff @(posedge clk) begin
      if (srst) begin
         grant_req_out       <= 1'b0;
         bus_outputs_oe      <= 1'b0;
         byte_lane_strobes_n <= LANES_NONE_N;
         strobes_oe          <= 1'b0;
         cache_out           <= 1'b0;
         cache_oe            <= 1'b0;
         core_done           <= 1'b0;
         bus_phase           <= LBL_IDLE;
      end else begin
         grant_req_out       <= role_primary ? (next_state == LBL_HOLD) : need_bus;
         bus_outputs_oe      <= next_drive;
         byte_lane_strobes_n <= next_strobes_n;
         strobes_oe          <= next_drive;
         cache_out           <= start_now ? pend_req.cacheable : cacheable;
         cache_oe            <= next_drive;
         core_done           <= last_ready;
         bus_phase           <= next_state;
      end
   end

endmodule : lbl_bus_lanes

/* File: lbl_bus_lanes_assertions.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Lane strobe and bus ownership checks
// ----------------------------------------------------------------------
module lbl_bus_lanes_assertions
   import lbl_pkg::*;
(
   input wire logic               clk,
   input wire logic               srst,
   input wire logic               ready_n,
   input wire logic               grant_req_in,
   input wire logic               grant_req_out,
   input wire logic               bus_outputs_oe,
   input wire logic [3:0]         byte_lane_strobes_n,
   input wire logic               cache_oe,
   input wire lbl_pkg::lbl_state_t bus_phase,
   input wire logic               role_primary
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Phase decodes shared by the properties.
   wire data_ph = (bus_phase == LBL_DATA) || (bus_phase == LBL_WAIT);
   wire busy_ph = data_ph || (bus_phase == LBL_ADDRESS);

   // Entering and leaving the released state are checked as steps.
   sequence s_hold_entry;
      grant_req_out && bus_phase == LBL_HOLD && !bus_outputs_oe && !cache_oe;
   endsequence
   sequence s_hold_exit;
      !grant_req_out && (bus_phase == LBL_IDLE || bus_phase == LBL_ADDRESS);
   endsequence

   a_lane_shape : assert property (
      bus_phase == LBL_ADDRESS |-> byte_lane_strobes_n inside {4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h3, 4'h0})
      else $error("lane pattern not aligned or empty");
   a_wait_holds_lanes : assert property (
      bus_phase == LBL_WAIT |-> $stable(byte_lane_strobes_n))
      else $error("lanes changed in a wait state");
   a_noready_waits : assert property (
      data_ph && ready_n |=> bus_phase == LBL_WAIT)
      else $error("missing wait state without ready");
   a_address_one_cycle : assert property (
      bus_phase == LBL_ADDRESS |=> bus_phase == LBL_DATA)
      else $error("address state not followed by data state");
   a_grant_enters_hold : assert property (
      role_primary && bus_phase == LBL_IDLE && grant_req_in |=> s_hold_entry)
      else $error("request in idle not granted");
   a_release_hold : assert property (
      role_primary && bus_phase == LBL_HOLD && !grant_req_in |=> s_hold_exit)
      else $error("grant not withdrawn after request removed");
   a_no_grant_midway : assert property (
      role_primary && busy_ph |-> !grant_req_out)
      else $error("grant inside a transaction");
   a_secondary_waits : assert property (
      !role_primary && bus_phase == LBL_ADDRESS |-> $past(grant_req_in) && grant_req_out)
      else $error("secondary started without grant");
   a_cache_driven : assert property (
      bus_phase == LBL_ADDRESS |-> cache_oe && bus_outputs_oe)
      else $error("cacheable indicator not driven");
   a_cache_floats : assert property (
      bus_phase == LBL_IDLE || bus_phase == LBL_HOLD |-> !cache_oe)
      else $error("cacheable indicator driven while idle");
endmodule : lbl_bus_lanes_assertions

/* File: lbl_far_side.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Far side: memory answering ready and a second bus master
// ----------------------------------------------------------------------
module lbl_far_side
   import lbl_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire lbl_pkg::lbl_state_t bus_phase,
   input  wire logic               role_primary,
   input  wire logic               grant_req_out,
   input  wire logic [1:0]         wait_cycles,
   input  wire logic               hold_go,
   output logic                    ready_n,
   output logic                    grant_req_in
);
   logic [1:0] wcnt;
   logic [1:0] hcnt;
   logic       hold_on;
   logic       gnt;

   // The ready line is pulled up; it is pulled low only when a word is due.
   wire data_ph = (bus_phase == LBL_DATA) || (bus_phase == LBL_WAIT);
   assign ready_n = !(data_ph && wcnt == 2'h0);
   // Primary role sees our bus request; secondary role sees our grant, one cycle late.
   assign grant_req_in = role_primary ? hold_on : gnt;

   // Wait counter reloads per word; the other master leaves after three granted cycles.
   always @(posedge clk) begin
      if (srst) begin
         wcnt <= 2'h0;
         hcnt <= 2'h0;
         hold_on <= 1'b0;
         gnt <= 1'b0;
      end else begin
         wcnt <= (bus_phase == LBL_ADDRESS || !ready_n) ? wait_cycles : wcnt - 2'h1;
         hcnt <= (hold_on && grant_req_out) ? hcnt + 2'h1 : 2'h0;
         hold_on <= hold_go || (hold_on && !(grant_req_out && hcnt == 2'h2));
         gnt <= grant_req_out;
      end
   end
endmodule : lbl_far_side

/* File: tb_top.sv */
`timescale 1ns/1ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 300) begin @(negedge clk); n++; end \
   if (n >= 300) begin err_count++; print_verdict(); end end

bind lbl_bus_lanes lbl_bus_lanes_assertions lbl_bus_lanes_assertions_inst (.clk, .srst, .ready_n,
   .grant_req_in, .grant_req_out, .bus_outputs_oe, .byte_lane_strobes_n, .cache_oe, .bus_phase, .role_primary);

// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module tb_top;
   import lbl_pkg::*;
   logic       clk, srst, interrupt_zero_pin, core_req_valid, ready_n, grant_req_in, hold_go;
   logic       core_req_ready, core_done, grant_req_out, bus_outputs_oe, strobes_oe;
   logic       cache_out, cache_oe, role_primary;
   logic [1:0] wait_cycles;
   logic [3:0] byte_lane_strobes_n;
   logic [15:0] r;
   lbl_req_t   core_req;
   lbl_state_t bus_phase;
   int         err_count, check_count, n, i;

   always #5 clk = ~clk;

   lbl_bus_lanes lbl_bus_lanes_inst (.clk, .srst, .interrupt_zero_pin, .core_req_valid, .core_req,
      .core_req_ready, .core_done, .ready_n, .grant_req_in, .grant_req_out, .bus_outputs_oe,
      .byte_lane_strobes_n, .strobes_oe, .cache_out, .cache_oe, .bus_phase, .role_primary);
   lbl_far_side lbl_far_side_inst (.clk, .srst, .bus_phase, .role_primary, .grant_req_out,
      .wait_cycles, .hold_go, .ready_n, .grant_req_in);

   // Next pseudo-random value.
   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Expected first-word lanes; bursts always move whole words.
   function logic [3:0] exp_mask(input lbl_size_t sz, input logic [1:0] off, input logic [1:0] wc);
      if (wc != 2'h0 || sz == LBL_SIZE_WORD) return 4'h0;
      if (sz == LBL_SIZE_HALF) return off[1] ? 4'h3 : 4'hC;
      return ~(4'h1 << off);
   endfunction : exp_mask

   // Low byte address bits as outside logic recovers them from the lowest asserted lane.
   function logic [1:0] low_addr_bits(input logic [3:0] lanes_n);
      logic [1:0] b;
      b = 2'h0;
      for (int k = 3; k >= 0; k--) if (!lanes_n[k]) b = k[1:0];
      return b;
   endfunction : low_addr_bits

   // Expected low byte address bits of the first word after alignment.
   function logic [1:0] exp_low_bits(input lbl_size_t sz, input logic [1:0] off, input logic [1:0] wc);
      if (wc != 2'h0 || sz == LBL_SIZE_WORD) return 2'h0;
      if (sz == LBL_SIZE_HALF) return {off[1], 1'b0};
      return off;
   endfunction : exp_low_bits

   task print_verdict;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task do_reset(input logic role);
      @(posedge clk);
      srst <= 1'b1;
      interrupt_zero_pin <= role;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      `CHK(role_primary, role)
      `CHK(bus_phase, LBL_IDLE)
      `CHK(byte_lane_strobes_n, LANES_NONE_N)
   endtask : do_reset

   task txn(input lbl_size_t sz, input logic [1:0] off, wc, wt, input logic cch);
      `WAITC(core_req_ready === 1'b1)
      @(posedge clk);
      core_req <= '{word_addr: {r, r[13:0]}, byte_off: off, size: sz, word_count: wc, cacheable: cch,
                    write: r[3]};
      core_req_valid <= 1'b1;
      wait_cycles <= wt;
      hold_go <= r[6] & r[7] & role_primary;
      @(posedge clk);
      core_req_valid <= 1'b0;
      hold_go <= r[11] & r[12] & role_primary;   // A request raised in mid-transaction must wait.
      @(posedge clk);
      hold_go <= 1'b0;
      @(negedge clk);
      `WAITC(bus_phase === LBL_ADDRESS)
      `CHK(byte_lane_strobes_n, exp_mask(sz, off, wc))
      `CHK(low_addr_bits(byte_lane_strobes_n), exp_low_bits(sz, off, wc))
      `CHK(strobes_oe, 1'b1)
      `CHK(cache_out, cch)
      `CHK(grant_req_out, !role_primary)
      @(negedge clk);
      if (wc != 2'h0) `CHK(byte_lane_strobes_n, LANES_ALL_N)
      `WAITC(core_done === 1'b1)
   endtask : txn

   task rand_txns(input int cnt);
      for (i = 0; i < cnt; i++) begin
         r = lfsr(r);
         txn(r[1:0] == 2'h3 ? LBL_SIZE_WORD : lbl_size_t'(r[1:0]), r[3:2], r[5:4], r[9:8], r[10]);
      end
   endtask : rand_txns

   // Main sequence: primary role hold, then corners, random traffic, then secondary role.
   initial begin
      clk = 0; srst = 1; interrupt_zero_pin = 1; core_req_valid = 0; core_req = '0;
      wait_cycles = 0; hold_go = 0; err_count = 0; check_count = 0; r = 16'h62FC;
      do_reset(1'b1);
      @(posedge clk) hold_go <= 1'b1;
      @(posedge clk) hold_go <= 1'b0;
      `WAITC(grant_req_out === 1'b1)
      `CHK(bus_phase, LBL_HOLD)
      `CHK(bus_outputs_oe, 1'b0)
      `CHK(strobes_oe, 1'b0)
      `WAITC(grant_req_out === 1'b0)
      `CHK(bus_phase, LBL_IDLE)
      for (i = 0; i < 12; i++) txn(lbl_size_t'(i / 4), i[1:0], 2'h0, i[1:0], i[0]);
      rand_txns(40);
      do_reset(1'b0);
      rand_txns(12);
      print_verdict();
   end
endmodule : tb_top
